// [hdl/scan_fifo.v]
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: one clock, synchronous active-low reset
// Notes:   read data comes from a register
`timescale 1ns/100ps
module scan_fifo #(
	parameter W  = 8,
	parameter D  = 32,
	parameter AW = 5
) (
	// clock and reset
	input  wire          clk_i,
	input  wire          rst_n_i,
	// fill side
	input  wire [W-1:0]  in_data_i,
	input  wire          in_valid_i,
	output wire          in_ready_o,
	// drain side
	output reg  [W-1:0]  out_data_o,
	output reg           out_valid_o,
	input  wire          out_ready_i
);
	reg [W-1:0]  mem [0:D-1];   // storage
	reg [AW-1:0] wr_ptr;        // write index
	reg [AW-1:0] rd_ptr;        // read index
	reg [AW:0]   count;         // words held in memory
	wire         push;          // word accepted
	wire         pop;           // word moved to output register
	// room left in memory
	assign in_ready_o = (count != D[AW:0]);
	assign push = in_valid_i && in_ready_o;
	// refill output register when empty or being taken
	assign pop = (count != {(AW+1){1'b0}}) &&
		(!out_valid_o || out_ready_i);
	// pointers, count and output register
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			wr_ptr      <= {AW{1'b0}};
			rd_ptr      <= {AW{1'b0}};
			count       <= {(AW+1){1'b0}};
			out_valid_o <= 1'b0;
			out_data_o  <= {W{1'b0}};
		end else begin
			if (push) begin
				mem[wr_ptr] <= in_data_i;
				wr_ptr      <= wr_ptr + 1'b1;
			end
			if (pop) begin
				out_data_o  <= mem[rd_ptr];
				rd_ptr      <= rd_ptr + 1'b1;
				out_valid_o <= 1'b1;
			end else if (out_ready_i) begin
				out_valid_o <= 1'b0;
			end
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end
endmodule

// [hdl/scan_tap.v]
// Purpose: boundary scan test access port with tap, ir and data regs
// Assumes: test pins are slow versus SYS_CLK_I and are oversampled
// Notes:   bytes shifted out of the data registers are also logged through a fifo
`timescale 1ns/100ps
`include "tap_consts.vh"
module scan_tap (
	// system clock and reset
	input  wire                 SYS_CLK_I,
	input  wire                 RST_N_I,
	// test port pins, pulled up externally when undriven
	input  wire                 TCK_I,
	input  wire                 TMS_I,
	input  wire                 TDI_I,
	input  wire                 TRST_N_I,
	output reg                  TDO_O,
	output reg                  TDO_OE_N_O,
	// device status
	input  wire                 PROGRAMMED_I,
	// core side of the io cells
	input  wire [`NUM_IO-1:0]   CORE_OUT_I,
	input  wire [`NUM_IO-1:0]   CORE_OE_I,
	output reg  [`NUM_IO-1:0]   CORE_IN_O,
	// pad side of the io cells
	input  wire [`NUM_IO-1:0]   PAD_IN_I,
	output reg  [`NUM_IO-1:0]   PAD_OUT_O,
	output reg  [`NUM_IO-1:0]   PAD_OE_N_O,
	output reg                  IO_EN_O,
	// shifted-out byte log
	output wire [`FIFO_W-1:0]   LOG_DATA_O,
	output wire                 LOG_VALID_O,
	input  wire                 LOG_READY_I,
	// current tap state
	output reg  [3:0]           TAP_STATE_O
);
	// pin synchronisers; mode, data and reset pins reset to one to match the pull-ups, the clock to zero
	reg [1:0] tck_s, tms_s, tdi_s, trst_s;  // two-stage samplers
	reg [`NUM_IO-1:0] pad_s0;               // pad input, first stage
	reg [`NUM_IO-1:0] pad_s1;               // pad input, second stage
	reg       tck_d;                        // previous synced clock
	reg [3:0] state;                        // tap state
	reg [3:0] next_state;                   // tap next state
	reg [`IR_W-1:0]  ir_sh;                 // ir shift stage
	reg [`IR_W-1:0]  ir;                    // current instruction
	reg              byp;                   // bypass bit
	reg [`ID_W-1:0]  dr32;                  // id / usercode shifter
	reg [`BSR_W-1:0] bsr;                   // boundary shift stage
	reg [`BSR_W-1:0] bsr_upd;               // boundary update stage
	reg [`FIFO_W-1:0] log_sh;               // shifted-out byte
	reg [2:0]        log_cnt;               // bits in log byte
	reg              log_push;              // byte ready to log
	wire             log_ready;             // fifo can take byte
	wire tck_rise = tck_s[1] & ~tck_d;      // clock rising edge
	wire tck_fall = ~tck_s[1] & tck_d;      // clock falling edge
	wire tms = tms_s[1];                    // synced mode select
	wire tdi = tdi_s[1];                    // synced data in
	// drop test clock rises while the log cannot take a byte
	wire step = tck_rise && !(log_push && !log_ready);
	integer k;                              // loop index, tap process
	integer j;                              // loop index, pad process

	// which data register an instruction selects
	localparam SEL_BYP = 2'd0;
	localparam SEL_ID  = 2'd1;
	localparam SEL_BSR = 2'd2;
	function [1:0] dr_sel;
		input [`IR_W-1:0] op;
		begin
			case (op)
				`OP_EXTEST, `OP_SAMPLE:    dr_sel = SEL_BSR;
				`OP_IDCODE, `OP_USERCODE:  dr_sel = SEL_ID;
				default:                   dr_sel = SEL_BYP;
			endcase
		end
	endfunction

	// tap next-state table driven by mode select
	always @* begin
		case (state)
			`ST_RESET:    next_state = tms ? `ST_RESET : `ST_IDLE;
			`ST_IDLE:     next_state = tms ? `ST_SEL_DR : `ST_IDLE;
			`ST_SEL_DR:   next_state = tms ? `ST_SEL_IR : `ST_CAP_DR;
			`ST_CAP_DR:   next_state = tms ? `ST_EXIT1_DR : `ST_SHIFT_DR;
			`ST_SHIFT_DR: next_state = tms ? `ST_EXIT1_DR : `ST_SHIFT_DR;
			`ST_EXIT1_DR: next_state = tms ? `ST_UPD_DR : `ST_PAUSE_DR;
			`ST_PAUSE_DR: next_state = tms ? `ST_EXIT2_DR : `ST_PAUSE_DR;
			`ST_EXIT2_DR: next_state = tms ? `ST_UPD_DR : `ST_SHIFT_DR;
			`ST_UPD_DR:   next_state = tms ? `ST_SEL_DR : `ST_IDLE;
			`ST_SEL_IR:   next_state = tms ? `ST_RESET : `ST_CAP_IR;
			`ST_CAP_IR:   next_state = tms ? `ST_EXIT1_IR : `ST_SHIFT_IR;
			`ST_SHIFT_IR: next_state = tms ? `ST_EXIT1_IR : `ST_SHIFT_IR;
			`ST_EXIT1_IR: next_state = tms ? `ST_UPD_IR : `ST_PAUSE_IR;
			`ST_PAUSE_IR: next_state = tms ? `ST_EXIT2_IR : `ST_PAUSE_IR;
			`ST_EXIT2_IR: next_state = tms ? `ST_UPD_IR : `ST_SHIFT_IR;
			`ST_UPD_IR:   next_state = tms ? `ST_SEL_DR : `ST_IDLE;
			default:      next_state = `ST_RESET;
		endcase
	end

	// two-flop sampling of the test pins
	always @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			tck_s  <= 2'b00;
			tms_s  <= 2'b11;
			tdi_s  <= 2'b11;
			trst_s <= 2'b11;
			tck_d  <= 1'b0;
			pad_s0 <= {`NUM_IO{1'b0}};
			pad_s1 <= {`NUM_IO{1'b0}};
		end else begin
			tck_s  <= {tck_s[0], TCK_I};
			tms_s  <= {tms_s[0], TMS_I};
			tdi_s  <= {tdi_s[0], TDI_I};
			trst_s <= {trst_s[0], TRST_N_I};
			tck_d  <= tck_s[1];
			// pads are asynchronous to the system clock as well
			pad_s0 <= PAD_IN_I;
			pad_s1 <= pad_s0;
		end
	end

	// tap state, instruction and data registers
	always @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			state   <= `ST_RESET;
			ir      <= `OP_IDCODE;
			ir_sh   <= {`IR_W{1'b0}};
			byp     <= 1'b0;
			dr32    <= {`ID_W{1'b0}};
			bsr     <= {`BSR_W{1'b0}};
			bsr_upd <= {`BSR_W{1'b0}};
		end else if (!trst_s[1]) begin
			// reset pin wins without waiting for a test clock edge
			state <= `ST_RESET;
			ir    <= `OP_IDCODE;
		end else if (step) begin
			state <= next_state;
			case (state)
				`ST_RESET:
					ir <= `OP_IDCODE;
				`ST_CAP_IR:
					ir_sh <= `IR_CAPTURE;
				`ST_SHIFT_IR:
					ir_sh <= {tdi, ir_sh[`IR_W-1:1]};
				`ST_UPD_IR:
					ir <= ir_sh;
				`ST_CAP_DR: begin
					byp <= 1'b0;
					if (ir == `OP_USERCODE)
						dr32 <= `USERCODE_VAL;
					else
						dr32 <= `IDCODE_VAL;
					// each io: input, output, control cells
					for (k = 0; k < `NUM_IO; k = k + 1) begin
						bsr[3*k]   <= pad_s1[k] & IO_EN_O;
						bsr[3*k+1] <= CORE_OUT_I[k];
						bsr[3*k+2] <= CORE_OE_I[k];
					end
				end
				`ST_SHIFT_DR: begin
					byp  <= tdi;
					dr32 <= {tdi, dr32[`ID_W-1:1]};
					bsr  <= {tdi, bsr[`BSR_W-1:1]};
				end
				`ST_UPD_DR:
					if (dr_sel(ir) == SEL_BSR)
						bsr_upd <= bsr;
				default: ;
			endcase
		end
	end

	// data out changes on the falling test clock
	always @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			TDO_O      <= 1'b0;
			TDO_OE_N_O <= 1'b1;
		end else if (!trst_s[1]) begin
			TDO_OE_N_O <= 1'b1;
		end else if (tck_fall) begin
			TDO_OE_N_O <= !(state == `ST_SHIFT_DR ||
				state == `ST_SHIFT_IR);
			if (state == `ST_SHIFT_IR)
				TDO_O <= ir_sh[0];
			else case (dr_sel(ir))
				SEL_ID:  TDO_O <= dr32[0];
				SEL_BSR: TDO_O <= bsr[0];
				default: TDO_O <= byp;
			endcase
		end
	end

	// pad and core drive from the update stage or functional path
	always @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			IO_EN_O     <= 1'b0;
			PAD_OUT_O   <= {`NUM_IO{1'b0}};
			PAD_OE_N_O  <= {`NUM_IO{1'b1}};
			CORE_IN_O   <= {`NUM_IO{1'b0}};
			TAP_STATE_O <= `ST_RESET;
		end else begin
			TAP_STATE_O <= state;
			// no instruction may raise the io enable when blank
			IO_EN_O <= PROGRAMMED_I;
			for (j = 0; j < `NUM_IO; j = j + 1) begin
				CORE_IN_O[j] <= pad_s1[j] & PROGRAMMED_I;
				if (!PROGRAMMED_I) begin
					PAD_OUT_O[j]  <= 1'b0;
					PAD_OE_N_O[j] <= 1'b1;
				end else if (ir == `OP_HIGHZ) begin
					PAD_OUT_O[j]  <= 1'b0;
					PAD_OE_N_O[j] <= 1'b1;
				end else if (ir == `OP_EXTEST || ir == `OP_CLAMP) begin
					PAD_OUT_O[j]  <= bsr_upd[3*j+1];
					PAD_OE_N_O[j] <= ~bsr_upd[3*j+2];
				end else begin
					PAD_OUT_O[j]  <= CORE_OUT_I[j];
					PAD_OE_N_O[j] <= ~CORE_OE_I[j];
				end
			end
		end
	end

	// collect bits shifted out in shift-dr into bytes for the log fifo
	always @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			log_sh   <= {`FIFO_W{1'b0}};
			log_cnt  <= 3'd0;
			log_push <= 1'b0;
		end else begin
			if (log_push && log_ready)
				log_push <= 1'b0;
			if (step && state == `ST_SHIFT_DR) begin
				log_sh  <= {TDO_O, log_sh[`FIFO_W-1:1]};
				log_cnt <= log_cnt + 3'd1;
				if (log_cnt == 3'd7)
					log_push <= 1'b1;
			end
		end
	end

	// byte log buffer
	scan_fifo #(
		.W  (`FIFO_W),
		.D  (`FIFO_D),
		.AW (`FIFO_AW)
	) u_log (
		.clk_i       (SYS_CLK_I),
		.rst_n_i     (RST_N_I),
		.in_data_i   (log_sh),
		.in_valid_i  (log_push),
		.in_ready_o  (log_ready),
		.out_data_o  (LOG_DATA_O),
		.out_valid_o (LOG_VALID_O),
		.out_ready_i (LOG_READY_I)
	);
endmodule

// [hdl/tap_consts.vh]
// Purpose: constants for the boundary scan test access port
// Assumes: included by bare name from the design files
// Notes:   tap states use the usual 4-bit codes
`ifndef TAP_CONSTS_VH
`define TAP_CONSTS_VH
// tap controller state codes
`define ST_RESET      4'hF
`define ST_IDLE       4'hC
`define ST_SEL_DR     4'h7
`define ST_CAP_DR     4'h6
`define ST_SHIFT_DR   4'h2
`define ST_EXIT1_DR   4'h1
`define ST_PAUSE_DR   4'h3
`define ST_EXIT2_DR   4'h0
`define ST_UPD_DR     4'h5
`define ST_SEL_IR     4'h4
`define ST_CAP_IR     4'hE
`define ST_SHIFT_IR   4'hA
`define ST_EXIT1_IR   4'h9
`define ST_PAUSE_IR   4'hB
`define ST_EXIT2_IR   4'h8
`define ST_UPD_IR     4'hD
// instruction opcodes
`define OP_EXTEST     8'h00
`define OP_SAMPLE     8'h01
`define OP_CLAMP      8'h05
`define OP_HIGHZ      8'h07
`define OP_USERCODE   8'h0E
`define OP_IDCODE     8'h0F
`define OP_BYPASS     8'hFF
// register widths
`define IR_W          8
`define ID_W          32
`define NUM_IO        4
`define BSR_W         12
// capture pattern for the instruction register
`define IR_CAPTURE    8'h01
// identification value, arbitrary neutral fields
`define IDCODE_VAL    32'h1234_5679
// user code default, arbitrary
`define USERCODE_VAL  32'h0000_0001
// fifo geometry for the shifted-out data log
`define FIFO_W        8
`define FIFO_D        32
`define FIFO_AW       5
`endif

// [tb/jtag_host.sv]
// Purpose: behavioural test controller on the four-pin port
// Assumes: link period is eight system clocks, 320 ns
// Notes:   link clock rests low, mode and data rest high between frames
`timescale 1ns/100ps
module jtag_host (
	// system clock
	input  wire clk_i,
	// test port
	output reg  tck_o,
	output reg  tms_o,
	output reg  tdi_o,
	input  wire tdo_i
);
	// pulled-up lines read high when idle
	initial begin
		tck_o = 1'b0;
		tms_o = 1'b1;
		tdi_o = 1'b1;
	end
	// one link cycle of eight clocks, four low and four high;
	// data out is taken late in the high half
	task tick(input logic tms, input logic tdi, output logic tdo);
		@(posedge clk_i);
		tms_o <= tms;
		tdi_o <= tdi;
		repeat (3) @(posedge clk_i);
		tck_o <= 1'b1;
		repeat (4) @(posedge clk_i);
		tdo = tdo_i;
		tck_o <= 1'b0;
	endtask
	// complete scan from idle back to idle, n bits lsb first
	task scan(input bit ir, input int n, input logic [31:0] din,
		output logic [31:0] dout);
		logic t;
		dout = 32'h0;
		tick(1'b1, 1'b1, t);
		if (ir) tick(1'b1, 1'b1, t);
		tick(1'b0, 1'b1, t);
		tick(1'b0, 1'b1, t);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], t);
			dout[i] = t;
		end
		tick(1'b1, 1'b1, t);
		tick(1'b0, 1'b1, t);
		@(posedge clk_i);
		tms_o <= 1'b1;
		tdi_o <= 1'b1;
	endtask
	// forced controller reset by five high mode cycles
	task five_high;
		logic t;
		repeat (5) tick(1'b1, 1'b1, t);
	endtask
endmodule

// [tb/scan_tap_properties.sv]
// Purpose: port-level checks for the scan tap block
// Assumes: one system clock, sync active-low reset
// Notes:   link edges are found by sampling the pin like the design
`timescale 1ns/100ps
`include "tap_consts.vh"
module scan_tap_props (
	// clock and reset
	input wire       SYS_CLK_I,
	input wire       RST_N_I,
	// test pins
	input wire       TCK_I,
	input wire       TMS_I,
	input wire       TDI_I,
	input wire       TRST_N_I,
	input wire       TDO_O,
	input wire       TDO_OE_N_O,
	// status and io cells
	input wire       PROGRAMMED_I,
	input wire [3:0] CORE_OUT_I,
	input wire [3:0] CORE_OE_I,
	input wire [3:0] CORE_IN_O,
	input wire [3:0] PAD_IN_I,
	input wire [3:0] PAD_OUT_O,
	input wire [3:0] PAD_OE_N_O,
	input wire       IO_EN_O,
	// log stream and state
	input wire [7:0] LOG_DATA_O,
	input wire       LOG_VALID_O,
	input wire       LOG_READY_I,
	input wire [3:0] TAP_STATE_O
);
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (!RST_N_I);
	reg [2:0] hi_cnt; // link rises seen with mode high
	reg       tck_q;  // last sampled link clock
	// count link rises with mode high, saturating at five
	always @(posedge SYS_CLK_I) begin
		tck_q <= TCK_I;
		if (!RST_N_I || (TCK_I && !tck_q && !TMS_I))
			hi_cnt <= 3'h0;
		else if (TCK_I && !tck_q && hi_cnt != 3'h5)
			hi_cnt <= hi_cnt + 3'h1;
	end
	rst_state_a: assert property ($rose(RST_N_I) |->
		TAP_STATE_O == `ST_RESET && TDO_OE_N_O && &PAD_OE_N_O)
		else $error("outputs not at reset values");
	io_off_a: assert property (!PROGRAMMED_I |=> !IO_EN_O)
		else $error("io enable on while unprogrammed");
	io_follow_a: assert property (PROGRAMMED_I |=> IO_EN_O)
		else $error("io enable not following programmed");
	pad_quiet_a: assert property (!PROGRAMMED_I [*2] |->
		&PAD_OE_N_O && CORE_IN_O == 4'h0)
		else $error("io active while unprogrammed");
	trst_force_a: assert property (!TRST_N_I [*6] |->
		TAP_STATE_O == `ST_RESET) else $error("test reset ignored");
	tms_five_a: assert property ($rose(hi_cnt == 3'h5) |->
		##[0:8] TAP_STATE_O == `ST_RESET) else $error("five high no reset");
	step_sel_a: assert property ($rose(TCK_I) && TMS_I && TRST_N_I &&
		TAP_STATE_O == `ST_IDLE |-> ##[2:7] TAP_STATE_O == `ST_SEL_DR)
		else $error("idle did not step on mode high");
	log_hold_a: assert property (LOG_VALID_O && !LOG_READY_I |=>
		LOG_VALID_O && $stable(LOG_DATA_O)) else $error("log byte lost");
	tdo_off_a: assert property ((TAP_STATE_O == `ST_IDLE) [*4] |->
		TDO_OE_N_O) else $error("data out driven in idle");
	cover property (TAP_STATE_O == `ST_SHIFT_IR);
	cover property (TAP_STATE_O == `ST_SHIFT_DR);
	cover property (LOG_VALID_O && LOG_READY_I);
endmodule
bind scan_tap scan_tap_props u_props (.*);

// [tb/tb_top.sv]
// Purpose: self-checking bench for the scan tap block
// Assumes: inputs change by non-blocking assignment at clock rise
// Notes:   bench signals carry the port names so the dut instance can use .* connections
`timescale 1ns/100ps
`include "tap_consts.vh"
module tb_top;
	// design-facing signals
	logic       SYS_CLK_I = 1'b0;
	logic       RST_N_I = 1'b0;
	logic       TRST_N_I = 1'b1;
	logic       PROGRAMMED_I = 1'b0;
	logic       LOG_READY_I = 1'b0;
	logic [3:0] CORE_OUT_I = 4'h6;
	logic [3:0] CORE_OE_I = 4'h3;
	logic [3:0] PAD_IN_I = 4'hA;
	wire        TCK_I, TMS_I, TDI_I, TDO_O, TDO_OE_N_O, IO_EN_O;
	wire        LOG_VALID_O;
	wire  [3:0] CORE_IN_O, PAD_OUT_O, PAD_OE_N_O, TAP_STATE_O;
	wire  [7:0] LOG_DATA_O;
	int         bad_count = 0;
	int         n_tests = 0;
	logic [31:0] got; // last scanned-out value
	logic       t;    // unused link sample
	logic [7:0] ops [4] = '{`OP_IDCODE, `OP_USERCODE, `OP_BYPASS, 8'h3C};
	scan_tap dut (.*);
	jtag_host host (.clk_i(SYS_CLK_I), .tck_o(TCK_I), .tms_o(TMS_I),
		.tdi_o(TDI_I), .tdo_i(TDO_OE_N_O ? ~TDO_O : TDO_O));
	// a released data-out line shows the inverse of its last bit
	// system clock, 40 ns
	initial forever #20 SYS_CLK_I = ~SYS_CLK_I;
	// summary and verdict
	task report_and_stop;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// compare one value
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask
	// boundary chain image: input, output, control per io
	function automatic logic [11:0] cells(logic [3:0] a, logic [3:0] b,
		logic [3:0] c);
		for (int k = 0; k < 4; k++) cells[3*k +: 3] = {c[k], b[k], a[k]};
	endfunction
	// load an instruction, capture pattern comes back
	task load(input logic [7:0] op);
		host.scan(1'b1, 8, {24'h0, op}, got);
		chk(got, `IR_CAPTURE);
	endtask
	// queue 32 bytes in the log with the consumer stalled, then drain it
	task t_fill;
		int w;
		for (int k = 0; k < 8; k++) begin
			host.scan(1'b0, 32, 32'h0, got);
			chk(got, `IDCODE_VAL);
		end
		LOG_READY_I <= 1'b1;
		for (int k = 0; k < 32; k++) begin
			w = 0;
			do begin
				@(posedge SYS_CLK_I);
				w++;
			end while (LOG_VALID_O !== 1'b1 && w < 50);
			if (LOG_VALID_O !== 1'b1) begin
				bad_count++;
				report_and_stop();
			end
			chk(LOG_DATA_O, (`IDCODE_VAL >> (8 * (k % 4))) & 32'hFF);
		end
		repeat (4) @(posedge SYS_CLK_I);
		chk(LOG_VALID_O, 1'b0);
	endtask
	// the id, usercode and bypass opcodes, plus an unknown one
	task t_ops;
		for (int k = 0; k < 4; k++) begin
			load(ops[k]);
			host.scan(1'b0, 32, 32'hA5C3_0F96, got);
			chk(got, k == 0 ? `IDCODE_VAL : k == 1 ? `USERCODE_VAL :
				32'h4B86_1F2C);
		end
	endtask
	// boundary capture, preload and pad control
	task t_bsr;
		load(`OP_SAMPLE);
		host.scan(1'b0, 12, 32'h0, got);
		chk(got, cells(4'h0, CORE_OUT_I, CORE_OE_I));
		chk({IO_EN_O, PAD_OE_N_O, CORE_IN_O}, 9'h0F0);
		PROGRAMMED_I <= 1'b1;
		repeat (2) @(posedge SYS_CLK_I);
		host.scan(1'b0, 12, cells(4'h0, 4'h9, 4'h5), got);
		chk(got, cells(PAD_IN_I, CORE_OUT_I, CORE_OE_I));
		chk({PAD_OUT_O, PAD_OE_N_O}, {CORE_OUT_I, ~CORE_OE_I});
		chk(CORE_IN_O, PAD_IN_I);
		load(`OP_EXTEST);
		chk({PAD_OUT_O, PAD_OE_N_O}, 8'h9A);
		load(`OP_HIGHZ);
		chk(PAD_OE_N_O, 4'hF);
		load(`OP_CLAMP);
		chk({PAD_OUT_O, PAD_OE_N_O}, 8'h9A);
	endtask
	// forced reset from shift and from the reset pin
	task t_resets;
		host.tick(1'b1, 1'b1, t);
		repeat (2) host.tick(1'b0, 1'b1, t);
		repeat (4) @(posedge SYS_CLK_I);
		chk(TAP_STATE_O, `ST_SHIFT_DR);
		chk(TDO_OE_N_O, 1'b0);
		host.five_high();
		repeat (3) @(posedge SYS_CLK_I);
		chk(TAP_STATE_O, `ST_RESET);
		host.tick(1'b0, 1'b1, t);
		load(`OP_BYPASS);
		host.tick(1'b1, 1'b1, t);
		TRST_N_I <= 1'b0;
		repeat (6) @(posedge SYS_CLK_I);
		chk(TAP_STATE_O, `ST_RESET);
		TRST_N_I <= 1'b1;
		host.tick(1'b0, 1'b1, t);
		host.scan(1'b0, 32, 32'h0, got);
		chk(got, `IDCODE_VAL);
	endtask
	// main sequence
	initial begin
		repeat (3) @(posedge SYS_CLK_I);
		RST_N_I <= 1'b1;
		repeat (4) @(posedge SYS_CLK_I);
		chk(TAP_STATE_O, `ST_RESET);
		host.tick(1'b0, 1'b1, t);
		t_fill();
		t_ops();
		t_bsr();
		t_resets();
		report_and_stop();
	end
endmodule
